// ### rto_defines.vh
// Purpose: Offsets, field positions and reset values of the radio test override registers.
// Assumes: Register addresses are 6-bit word indices on the device register port.
// Notes: Definitions only.
`ifndef RTO_DEFINES_VH
`define RTO_DEFINES_VH
`define RTO_ADDR_W 6
`define RTO_OFS_RX_FILTER_CAP_TEST 6'h2b
`define RTO_OFS_RADIO_FSM_STATE_READOUT 6'h2c
`define RTO_OFS_RX_CONVERTER_TEST 6'h2d
`define RTO_OFS_TX_CONVERTER_SOURCE_TEST 6'h2e
`define RTO_OFS_TOP_LEVEL_TEST_CONTROL 6'h2f
`define RTO_OFS_SPARE_CONTROL_STATUS 6'h30
`define RTO_CAP_OE_BIT 14
`define RTO_CAP_VAL_HI 13
`define RTO_CAP_VAL_LO 7
`define RTO_ADC_CLKDIS_BIT 15
`define RTO_TX_CONVERTER_SOURCE_SEL_HI 14
`define RTO_TX_CONVERTER_SOURCE_SEL_LO 12
`define RTO_DAC_I_HI 11
`define RTO_DAC_I_LO 6
`define RTO_DAC_Q_HI 5
`define RTO_DAC_Q_LO 0
`define RTO_BIST_BIT 7
`define RTO_BATMON_BIT 6
`define RTO_TUNE_SEL_BIT 5
`define RTO_ATEST_PD_BIT 4
`define RTO_ROUTE_HI 3
`define RTO_ROUTE_LO 0
`define RTO_RST_CAP_TEST 8'h00
`define RTO_RST_ADC_CLKDIS 1'h0
`define RTO_RST_DAC_TEST 15'h0000
`define RTO_RST_TOP_TEST 8'h10
`define RTO_RST_SPARE 16'h0000
`define RTO_SRC_MODULATOR 3'h0
`define RTO_SRC_OVERRIDE 3'h1
`define RTO_SRC_ADC_HIGH 3'h2
`define RTO_SRC_FILTERED 3'h3
`define RTO_SRC_NOISE 3'h4
`define RTO_SRC_ADC_LOW 3'h5
`define RTO_SRC_MAGNITUDE 3'h6
`define RTO_SRC_TESTMOD 3'h7
`define RTO_ROUTE_TUNE 4'h7
`define RTO_ROUTE_MAX 4'h8
`endif

// ### rto_radio_test_override_regs.v
// Purpose: Test and override register bank of the radio transceiver.
// Assumes: One clock, synchronous active-high reset, single-cycle register port.
// Notes: Live inputs come from logic on the same clock and are not synchronised.
`timescale 1ns/1ns
`include "rto_defines.vh"

// How it works
// - Override enable swaps the calibrated filter capacitance for the override value.
// - Calibration result is a read-only 7-bit field, 0 smallest, 127 largest.
// - State readout returns the 6-bit radio state machine state, upper bits zero.
// - Converter clock runs when enabled unless the gate bit is set.
// - Converter test register reads live I sample 14:8 and Q sample 6:0.
// - Three-bit source field picks one of eight transmit converter inputs.
// - Override source drives I from bits 11:6 and Q from bits 5:0.
// - Self-test run bit starts memory self-test, result goes to the result output while set.
// - Battery monitor test enable routes monitor result to the test output.
// - Analog test power-down resets set; clearing it powers the module up.
// - Route field acts only while powered up; codes 0 to 8 valid.
// - At route seven the tune select chooses pin output or pin drive.
// - Spare register is plain 16-bit read/write, resets zero, no effect.
// - Tune select clear lets the synthesizer loop bit choose tuning source.
module rto_radio_test_override_regs (
  input wire clock,
  input wire reset,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire [6:0] filter_cap_cal_result,
  input wire [5:0] radio_fsm_state,
  input wire [6:0] rx_adc_i,
  input wire [6:0] rx_adc_q,
  input wire rx_adc_enable,
  input wire synth_loop_source_sel,
  input wire [5:0] tx_mod_i,
  input wire [5:0] tx_mod_q,
  input wire [5:0] tx_filt_i,
  input wire [5:0] tx_filt_q,
  input wire [5:0] tx_noise_i,
  input wire [5:0] tx_noise_q,
  input wire [5:0] tx_mag_i,
  input wire [5:0] tx_mag_q,
  input wire [5:0] tx_testmod_i,
  input wire [5:0] tx_testmod_q,
  input wire bist_result,
  input wire battery_monitor_result,
  output reg [6:0] rx_filter_cap,
  output reg rx_adc_clock_en,
  output reg [5:0] tx_dac_i,
  output reg [5:0] tx_dac_q,
  output reg memory_selftest_run,
  output reg bist_result_out,
  output reg battery_monitor_test_out_en,
  output reg battery_monitor_test_out,
  output reg analog_test_powerdown,
  output reg [3:0] analog_test_route,
  output reg analog_route_valid,
  output reg tune_node_drive_sel,
  output reg tune_pin_output,
  output reg tune_pin_drive,
  output reg tune_from_synth_sel
);

  // Only writable bits are stored; reserved and read-only bits have no flops.
  reg [7:0] cap_test_q;
  reg adc_clkdis_q;
  reg [14:0] dac_test_q;
  reg [7:0] top_test_q;
  reg [15:0] spare_q;

  function is_wr;
    input [5:0] addr;
    input [5:0] ofs;
    input wr;
    begin
      is_wr = wr && (addr == ofs);
    end
  endfunction

  wire [3:0] route;
  wire powered;
  wire route_ok;
  wire [2:0] src;
  assign route = top_test_q[`RTO_ROUTE_HI:`RTO_ROUTE_LO];
  assign powered = !top_test_q[`RTO_ATEST_PD_BIT];
  assign route_ok = powered && (route <= `RTO_ROUTE_MAX);
  assign src = dac_test_q[`RTO_TX_CONVERTER_SOURCE_SEL_HI:`RTO_TX_CONVERTER_SOURCE_SEL_LO];

  always @(posedge clock) begin
    if (reset) begin
      cap_test_q <= `RTO_RST_CAP_TEST;
      adc_clkdis_q <= `RTO_RST_ADC_CLKDIS;
      dac_test_q <= `RTO_RST_DAC_TEST;
      top_test_q <= `RTO_RST_TOP_TEST;
      spare_q <= `RTO_RST_SPARE;
    end else begin
      // Reserved bits are dropped on write, so a careless write cannot disturb them.
      if (is_wr(reg_addr, `RTO_OFS_RX_FILTER_CAP_TEST, reg_wr)) begin
        cap_test_q <= reg_wdata[`RTO_CAP_OE_BIT:`RTO_CAP_VAL_LO];
      end
      if (is_wr(reg_addr, `RTO_OFS_RX_CONVERTER_TEST, reg_wr)) begin
        adc_clkdis_q <= reg_wdata[`RTO_ADC_CLKDIS_BIT];
      end
      if (is_wr(reg_addr, `RTO_OFS_TX_CONVERTER_SOURCE_TEST, reg_wr)) begin
        dac_test_q <= reg_wdata[14:0];
      end
      if (is_wr(reg_addr, `RTO_OFS_TOP_LEVEL_TEST_CONTROL, reg_wr)) begin
        top_test_q <= reg_wdata[7:0];
      end
      if (is_wr(reg_addr, `RTO_OFS_SPARE_CONTROL_STATUS, reg_wr)) begin
        spare_q <= reg_wdata;
      end
    end
  end

  // Read data registered one cycle after the read strobe; unmapped reads give zero.
  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `RTO_OFS_RX_FILTER_CAP_TEST: reg_rdata <= {1'b0, cap_test_q, filter_cap_cal_result};
        `RTO_OFS_RADIO_FSM_STATE_READOUT: reg_rdata <= {10'h000, radio_fsm_state};
        `RTO_OFS_RX_CONVERTER_TEST: reg_rdata <= {adc_clkdis_q, rx_adc_i, 1'b0, rx_adc_q};
        `RTO_OFS_TX_CONVERTER_SOURCE_TEST: reg_rdata <= {1'b0, dac_test_q};
        `RTO_OFS_TOP_LEVEL_TEST_CONTROL: reg_rdata <= {8'h00, top_test_q};
        `RTO_OFS_SPARE_CONTROL_STATUS: reg_rdata <= spare_q;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  reg [5:0] dac_i_d;
  reg [5:0] dac_q_d;
  always @* begin
    case (src)
      `RTO_SRC_MODULATOR: begin
        dac_i_d = tx_mod_i;
        dac_q_d = tx_mod_q;
      end
      `RTO_SRC_OVERRIDE: begin
        dac_i_d = dac_test_q[`RTO_DAC_I_HI:`RTO_DAC_I_LO];
        dac_q_d = dac_test_q[`RTO_DAC_Q_HI:`RTO_DAC_Q_LO];
      end
      `RTO_SRC_ADC_HIGH: begin
        dac_i_d = rx_adc_i[6:1];
        dac_q_d = rx_adc_q[6:1];
      end
      `RTO_SRC_FILTERED: begin
        dac_i_d = tx_filt_i;
        dac_q_d = tx_filt_q;
      end
      `RTO_SRC_NOISE: begin
        dac_i_d = tx_noise_i;
        dac_q_d = tx_noise_q;
      end
      `RTO_SRC_ADC_LOW: begin
        dac_i_d = rx_adc_i[5:0];
        dac_q_d = rx_adc_q[5:0];
      end
      `RTO_SRC_MAGNITUDE: begin
        dac_i_d = tx_mag_i;
        dac_q_d = tx_mag_q;
      end
      default: begin
        dac_i_d = tx_testmod_i;
        dac_q_d = tx_testmod_q;
      end
    endcase
  end

  wire tune_mode;
  assign tune_mode = route_ok && (route == `RTO_ROUTE_TUNE);

  // Control outputs are registered, so each follows its field one cycle late.
  always @(posedge clock) begin
    if (reset) begin
      rx_filter_cap <= 7'h00;
      rx_adc_clock_en <= 1'b0;
      tx_dac_i <= 6'h00;
      tx_dac_q <= 6'h00;
      memory_selftest_run <= 1'b0;
      bist_result_out <= 1'b0;
      battery_monitor_test_out_en <= 1'b0;
      battery_monitor_test_out <= 1'b0;
      analog_test_powerdown <= 1'b1;
      analog_test_route <= 4'h0;
      analog_route_valid <= 1'b0;
      tune_node_drive_sel <= 1'b0;
      tune_pin_output <= 1'b0;
      tune_pin_drive <= 1'b0;
      tune_from_synth_sel <= 1'b0;
    end else begin
      rx_filter_cap <= cap_test_q[7] ? cap_test_q[6:0] : filter_cap_cal_result;
      rx_adc_clock_en <= rx_adc_enable && !adc_clkdis_q;
      tx_dac_i <= dac_i_d;
      tx_dac_q <= dac_q_d;
      memory_selftest_run <= top_test_q[`RTO_BIST_BIT];
      bist_result_out <= top_test_q[`RTO_BIST_BIT] && bist_result;
      battery_monitor_test_out_en <= top_test_q[`RTO_BATMON_BIT];
      battery_monitor_test_out <= top_test_q[`RTO_BATMON_BIT] && battery_monitor_result;
      analog_test_powerdown <= top_test_q[`RTO_ATEST_PD_BIT];
      analog_test_route <= route;
      analog_route_valid <= route_ok;
      tune_node_drive_sel <= top_test_q[`RTO_TUNE_SEL_BIT];
      tune_pin_output <= tune_mode && !top_test_q[`RTO_TUNE_SEL_BIT];
      tune_pin_drive <= tune_mode && top_test_q[`RTO_TUNE_SEL_BIT];
      tune_from_synth_sel <= !top_test_q[`RTO_TUNE_SEL_BIT] && synth_loop_source_sel;
    end
  end

endmodule

// ### rto_chk.sv
// Purpose: Port-level assertions for the radio test override register bank.
// Assumes: Derived outputs are registered together, one cycle after their cause.
// Notes: Bound to the bank; watches its ports only.
`timescale 1ns/1ns
module rto_chk (
  input wire clock,
  input wire reset,
  input wire [5:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [5:0] radio_fsm_state,
  input wire rx_adc_enable,
  input wire synth_loop_source_sel,
  input wire bist_result,
  input wire battery_monitor_result,
  input wire rx_adc_clock_en,
  input wire memory_selftest_run,
  input wire bist_result_out,
  input wire battery_monitor_test_out_en,
  input wire battery_monitor_test_out,
  input wire analog_test_powerdown,
  input wire [3:0] analog_test_route,
  input wire analog_route_valid,
  input wire tune_node_drive_sel,
  input wire tune_pin_output,
  input wire tune_pin_drive,
  input wire tune_from_synth_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  state_read_a: assert property (reg_rd && reg_addr == 6'h2c |=>
    reg_rdata == {10'h0, $past(radio_fsm_state)}) else $error("state readout wrong");
  adc_clock_a: assert property (rx_adc_clock_en |-> $past(rx_adc_enable))
    else $error("converter clock without enable");
  bist_out_a: assert property (bist_result_out == (memory_selftest_run && $past(bist_result)))
    else $error("self-test result gating wrong");
  batmon_out_a: assert property (battery_monitor_test_out ==
    (battery_monitor_test_out_en && $past(battery_monitor_result))) else $error("monitor gating");
  pd_reset_a: assert property ($past(reset) |-> analog_test_powerdown)
    else $error("power-down not set after reset");
  route_ok_a: assert property (analog_route_valid ==
    (!analog_test_powerdown && analog_test_route <= 4'h8)) else $error("route valid wrong");
  tune_pin_a: assert property ({tune_pin_output, tune_pin_drive} ==
    ({2{analog_route_valid && analog_test_route == 4'h7}} & {!tune_node_drive_sel,
    tune_node_drive_sel})) else $error("tune pin mode wrong");
  synth_sel_a: assert property (!$past(reset) |-> tune_from_synth_sel ==
    (!tune_node_drive_sel && $past(synth_loop_source_sel))) else $error("synth select wrong");
endmodule
bind rto_radio_test_override_regs rto_chk chk (.*);

// ### tb.sv
// Purpose: Self-checking bench for the radio test override register bank.
// Assumes: Live inputs other than rx_adc_enable, which is held at 1, are random but held steady while checked.
// Notes: Reads are queued by the driver and compared by a monitor.
`timescale 1ns/1ns
module tb;
  logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, v;
  logic rx_adc_enable = 1, synth_loop_source_sel, bist_result, battery_monitor_result;
  logic [5:0] reg_addr = 0, radio_fsm_state, tx_mod_i, tx_mod_q, tx_filt_i, tx_filt_q;
  logic [5:0] tx_noise_i, tx_noise_q, tx_mag_i, tx_mag_q, tx_testmod_i, tx_testmod_q;
  logic [6:0] filter_cap_cal_result, rx_adc_i, rx_adc_q;
  logic [15:0] reg_wdata = 0, e, r0 [6], exp_q [$];
  // Write masks keep every reserved bit of the mapped registers at zero, as software must; unmapped 31 gets all ones.
  logic [15:0] wm [7] = '{16'h7fff, 16'h003f, 16'hff7f, 16'h7fff, 16'h00ff, 16'hffff, 16'hffff};
  logic [95:0] rnd;
  int err_count = 0, check_count = 0;
  wire [15:0] reg_rdata;
  wire [6:0] rx_filter_cap;
  wire [5:0] tx_dac_i, tx_dac_q;
  wire [3:0] analog_test_route;
  wire rx_adc_clock_en, memory_selftest_run, bist_result_out, battery_monitor_test_out_en;
  wire battery_monitor_test_out, analog_test_powerdown, analog_route_valid;
  wire tune_node_drive_sel, tune_pin_output, tune_pin_drive, tune_from_synth_sel;
  rto_radio_test_override_regs dut (.*);
  always #5 clock = ~clock;
  always @(posedge clock) rd_q <= reg_rd;
  always @(negedge clock) if (rd_q) chk("rdata", exp_q.pop_front(), reg_rdata);
  task chk(input string n, input [15:0] ex, input [15:0] got);
    check_count++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, ex, got);
    end
  endtask
  task wr(input [5:0] a, input [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clock);
    reg_wr = 0;
    repeat (2) @(negedge clock);
  endtask
  task rd(input [5:0] a, input [15:0] ex);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1;
    exp_q.push_back(ex);
    @(negedge clock);
    reg_rd = 0;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    finish_test;
  end
  initial begin
    void'($urandom(5631));
    rnd = {$urandom, $urandom, $urandom};
    {filter_cap_cal_result, radio_fsm_state, rx_adc_i, rx_adc_q, synth_loop_source_sel,
      bist_result, battery_monitor_result, tx_mod_i, tx_mod_q, tx_filt_i, tx_filt_q, tx_noise_i,
      tx_noise_q, tx_mag_i, tx_mag_q, tx_testmod_i, tx_testmod_q} = rnd[89:0];
    repeat (16) @(negedge clock);
    reset = 0;
    r0 = '{{9'h0, filter_cap_cal_result}, {10'h0, radio_fsm_state},
      {1'b0, rx_adc_i, 1'b0, rx_adc_q}, 16'h0, 16'h0010, 16'h0};
    repeat (2) @(negedge clock);
    chk("pd cap clk", {1'b1, rx_adc_enable, filter_cap_cal_result},
      {analog_test_powerdown, rx_adc_clock_en, rx_filter_cap});
    for (int i = 0; i < 7; i++) rd(6'h2b + i, i < 6 ? r0[i] : 16'h0);
    for (int i = 0; i < 7; i++) wr(6'h2b + i, wm[i]);
    r0 = '{{2'b01, 7'h7f, filter_cap_cal_result}, r0[1], {1'b1, r0[2][14:0]}, 16'h7fff, 16'h00ff,
      16'hffff};
    for (int i = 0; i < 7; i++) rd(6'h2b + i, i < 6 ? r0[i] : 16'h0);
    chk("cap clk", 16'h7f, {rx_adc_clock_en, rx_filter_cap});
    wr(6'h2f, 16'h0004);
    for (int i = 0; i < 8; i++) begin
      wr(6'h2e, {1'b0, i[2:0], 12'habc});
      e = i == 1 ? 16'habc : i == 2 ? {rx_adc_i[6:1], rx_adc_q[6:1]} : i == 3 ? {tx_filt_i,
        tx_filt_q} : i == 4 ? {tx_noise_i, tx_noise_q} : i == 5 ? {rx_adc_i[5:0], rx_adc_q[5:0]} :
        i == 6 ? {tx_mag_i, tx_mag_q} : i == 7 ? {tx_testmod_i, tx_testmod_q} : {tx_mod_i, tx_mod_q};
      chk("dac", e, {tx_dac_i, tx_dac_q});
    end
    for (int i = 0; i < 64; i++) begin
      wr(6'h2f, {8'h0, i[1], i[2], i[4], i[5], i[3:0]});
      v = !i[5] && i[3:0] <= 4'h8;
      e = {v, v && i[3:0] == 7 && !i[4], v && i[3:0] == 7 && i[4], !i[4] && synth_loop_source_sel,
        i[1] & bist_result, i[2] & battery_monitor_result, i[5], i[3:0]};
      chk("test ctl", e, {analog_route_valid, tune_pin_output, tune_pin_drive, tune_from_synth_sel,
        bist_result_out, battery_monitor_test_out, analog_test_powerdown, analog_test_route});
    end
    finish_test;
  end
endmodule
